// >>> inc/dhf_pkg.sv
// Shared constants for the header field and test monitor register bank
package dhf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CODE0    = 8'h40; // Code for lowest rate
  localparam logic [7:0] OFS_CODE1    = 8'h44;
  localparam logic [7:0] OFS_CODE2    = 8'h48;
  localparam logic [7:0] OFS_CODE3    = 8'h4c; // Code for highest rate
  localparam logic [7:0] OFS_TX_CTRL  = 8'h50; // Transmit rate select
  localparam logic [7:0] OFS_TX_SVC   = 8'h54;
  localparam logic [7:0] OFS_TX_LENH  = 8'h58;
  localparam logic [7:0] OFS_TX_LENL  = 8'h5c;
  localparam logic [7:0] OFS_RX_STAT  = 8'h60;
  localparam logic [7:0] OFS_RX_SVC   = 8'h64;
  localparam logic [7:0] OFS_RX_LENH  = 8'h68;
  localparam logic [7:0] OFS_RX_LENL  = 8'h6c;
  localparam logic [7:0] OFS_TB_SEL   = 8'h70;
  localparam logic [7:0] OFS_TB_MON   = 8'h74; // Test bus monitor readback
  // Values after reset
  localparam logic [7:0] RST_CODE0    = 8'h0a;
  localparam logic [7:0] RST_CODE1    = 8'h14;
  localparam logic [7:0] RST_CODE2    = 8'h37;
  localparam logic [7:0] RST_CODE3    = 8'h6e;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  // Rate encodings
  localparam logic [1:0] RATE_DBPSK   = 2'h0; // 1 Mbit/s
  localparam logic [1:0] RATE_DQPSK   = 2'h1; // 2 Mbit/s
  localparam logic [1:0] RATE_BWALSH  = 2'h2; // 5.5 Mbit/s
  localparam logic [1:0] RATE_QWALSH  = 2'h3; // 11 Mbit/s
  // Receive status field positions
  localparam int ST_RATE_LSB = 6;
  localparam int ST_ACQ      = 5;
  localparam int ST_SFD      = 4;
  localparam int ST_SIG      = 3;
  localparam int ST_CRC      = 2;
  localparam int ST_ANT      = 1;
  // Test bus groups
  localparam logic [7:0] TB_QUIET     = 8'h00;
  localparam logic [7:0] TB_RX_ACQ    = 8'h01;
  localparam logic [7:0] TB_TX_FIELD  = 8'h02;
  // Header timing after delimiter detect
  localparam int CLK_MHZ     = 125;
  localparam int SIG_RDY_US  = 8;
  localparam int LEN_RDY_US  = 32;
  localparam int CRC_RDY_US  = 48;
  localparam int SIG_RDY_CYC = SIG_RDY_US * CLK_MHZ;
  localparam int LEN_RDY_CYC = LEN_RDY_US * CLK_MHZ;
  localparam int CRC_RDY_CYC = CRC_RDY_US * CLK_MHZ;
  localparam int TMR_W       = 16;
endpackage : dhf_pkg

// >>> rtl/dhf_sync.sv
// Two-stage synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module dhf_sync (
  // Clock and reset
  input  wire logic SYS_CLK,
  input  wire logic NRST,
  // Level in and out
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic meta; // First stage, read only by second
    logic sync; // Second stage
  } dhf_sync_s;

  dhf_sync_s st_r;  // Current state
  dhf_sync_s st_nxt; // Next state

  // Shift the pin through both stages
  always_comb begin
    st_nxt.meta = din;
    st_nxt.sync = st_r.meta;
  end

  // Constant reset only
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.sync;
endmodule // dhf_sync
`default_nettype wire

// >>> rtl/dhf_hdr_timer.sv
// Header field ready timer started by delimiter detect
`timescale 1ns/1ps
`default_nettype none
module dhf_hdr_timer #(
  parameter int TMR_W   = 16,
  parameter int SIG_CYC = 1000,
  parameter int LEN_CYC = 4000,
  parameter int CRC_CYC = 6000
) (
  // Clock and reset
  input  wire logic SYS_CLK,
  input  wire logic NRST,
  // Control
  input  wire logic sfd_det,  // Delimiter detected, level
  // Ready markers
  output logic      sig_rdy,
  output logic      len_rdy,
  output logic      crc_due
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt; // Cycles since delimiter
  } dhf_tmr_s;

  dhf_tmr_s st_r;  // Current state
  dhf_tmr_s st_nxt; // Next state

  localparam logic [TMR_W-1:0] SIG_T = TMR_W'(SIG_CYC);
  localparam logic [TMR_W-1:0] LEN_T = TMR_W'(LEN_CYC);
  localparam logic [TMR_W-1:0] CRC_T = TMR_W'(CRC_CYC);

  // Count while delimiter seen; saturate so a long frame cannot wrap
  always_comb begin
    st_nxt = st_r;
    if (!sfd_det) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt < CRC_T) begin
      st_nxt.cnt = st_r.cnt + TMR_W'(1);
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Markers rise in order and fall with the delimiter level
  assign sig_rdy = sfd_det && (st_r.cnt >= SIG_T);
  assign len_rdy = sfd_det && (st_r.cnt >= LEN_T);
  assign crc_due = sfd_det && (st_r.cnt >= CRC_T);
endmodule // dhf_hdr_timer
`default_nettype wire

// >>> rtl/dhf_regs.sv
// Header field configuration, receive status and test monitor registers
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dhf_regs
  import dhf_pkg::*;
#(
  parameter int SIG_CYC = dhf_pkg::SIG_RDY_CYC,
  parameter int LEN_CYC = dhf_pkg::LEN_RDY_CYC,
  parameter int CRC_CYC = dhf_pkg::CRC_RDY_CYC
) (
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       NRST,
  // Register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Receive path enable pin, asynchronous
  input  wire logic       RECEIVE_PATH_ENABLE_PIN,
  // Receive header decoder, same clock
  input  wire logic       RX_ACQUIRED,
  input  wire logic       RX_SFD_FOUND,
  input  wire logic       RX_SIG_STB,
  input  wire logic [7:0] RX_SIG_FIELD,
  input  wire logic       RX_HDR_STB,
  input  wire logic [7:0] RX_SERVICE,
  input  wire logic [15:0] RX_LENGTH,
  input  wire logic       RX_CRC_STB,
  input  wire logic       RX_CRC_OK,
  input  wire logic       RX_ANT_A,
  // Monitor sources, same clock
  input  wire logic       CHIP_TICK,
  input  wire logic       ADC_FULL_SCALE,
  input  wire logic       CARRIER_SENSE_FLAG,
  input  wire logic       ENERGY_DETECT_FLAG,
  input  wire logic       RX_TRACK,
  input  wire logic       RX_INIT_DETECT,
  input  wire logic [5:0] TX_FIELD_FLAGS,
  input  wire logic       TX_PE_DELAYED,
  input  wire logic       SYMBOL_BOUNDARY_MARKER,
  // Transmit header fields
  output logic      [1:0] TX_RATE,
  output logic      [7:0] TX_SIG_CODE,
  output logic      [7:0] TX_SERVICE,
  output logic     [15:0] TX_LENGTH,
  // Test pins
  output logic      [7:0] TEST_OUT,
  output logic            TEST_STB
);
  import dhf_pkg::*;

  // Whole register state
  typedef struct packed {
    logic [3:0][7:0] code;     // Signal field codes per rate
    logic [7:0]      tx_ctrl;  // Rate in 1:0, rest stored only
    logic [7:0]      tx_svc;   // Service byte to send
    logic [7:0]      tx_lenh;  // Length bits 15:8
    logic [7:0]      tx_lenl;  // Length bits 7:0
    logic [7:0]      tb_sel;   // Test group select
    logic [7:0]      tx_code;  // Selected transmit code
    logic [1:0]      rx_rate;  // Detected rate
    logic            rx_acq;   // Carrier acquired
    logic            rx_sfd;   // Delimiter found
    logic            rx_sig;   // Signal field valid
    logic            rx_crc;   // Header CRC valid
    logic            rx_ant;   // Antenna A at last good CRC
    logic [7:0]      rx_svc;   // Decoded service
    logic [15:0]     rx_len;   // Decoded length
    logic [7:0]      test;     // Test pin levels
    logic            test_stb; // Test strobe
    logic [7:0]      rdata;    // Read data, one cycle late
  } dhf_regs_s;

  dhf_regs_s st_r;   // Current state
  dhf_regs_s st_nxt; // Next state

  logic rx_en_s;  // Synchronised receive path enable
  logic sig_rdy;  // Signal field ready marker
  logic len_rdy;  // Length field ready marker
  logic crc_due;  // Header CRC time reached
  logic [7:0] rx_status; // Assembled status byte
  logic [7:0] sel_code;  // Code chosen by current rate

  // Match a received field to the code table
  function automatic logic code_hit(input logic [3:0][7:0] tbl,
                                    input logic [7:0] fld);
    code_hit = (fld == tbl[0]) || (fld == tbl[1]) ||
               (fld == tbl[2]) || (fld == tbl[3]);
  endfunction

  // Rate index of a matching code
  function automatic logic [1:0] code_rate(input logic [3:0][7:0] tbl,
                                           input logic [7:0] fld);
    code_rate = RATE_DBPSK;
    if (fld == tbl[1]) code_rate = RATE_DQPSK;
    if (fld == tbl[2]) code_rate = RATE_BWALSH;
    if (fld == tbl[3]) code_rate = RATE_QWALSH;
  endfunction

  // Pin crosses into the clock domain first
  dhf_sync u_pe_sync (
    .SYS_CLK (SYS_CLK),
    .NRST    (NRST),
    .din     (RECEIVE_PATH_ENABLE_PIN),
    .dout    (rx_en_s)
  );

  // Header ready markers follow the delimiter level
  dhf_hdr_timer #(
    .TMR_W   (TMR_W),
    .SIG_CYC (SIG_CYC),
    .LEN_CYC (LEN_CYC),
    .CRC_CYC (CRC_CYC)
  ) u_timer (
    .SYS_CLK (SYS_CLK),
    .NRST    (NRST),
    .sfd_det (RX_SFD_FOUND),
    .sig_rdy (sig_rdy),
    .len_rdy (len_rdy),
    .crc_due (crc_due)
  );

  assign sel_code = st_r.code[st_r.tx_ctrl[1:0]];

  // Status byte, bit 0 tied low
  assign rx_status = {st_r.rx_rate, st_r.rx_acq, st_r.rx_sfd,
                      st_r.rx_sig, st_r.rx_crc, st_r.rx_ant,
                      1'b0};

  // Next-state logic for all registers
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    // Software writes; read-only offsets fall through untouched
    if (REG_WR) begin
      case (REG_ADDR)
        OFS_CODE0:   st_nxt.code[0] = REG_WDATA;
        OFS_CODE1:   st_nxt.code[1] = REG_WDATA;
        OFS_CODE2:   st_nxt.code[2] = REG_WDATA;
        OFS_CODE3:   st_nxt.code[3] = REG_WDATA;
        OFS_TX_CTRL: st_nxt.tx_ctrl = REG_WDATA;
        OFS_TX_SVC:  st_nxt.tx_svc  = REG_WDATA;
        OFS_TX_LENH: st_nxt.tx_lenh = REG_WDATA;
        OFS_TX_LENL: st_nxt.tx_lenl = REG_WDATA;
        OFS_TB_SEL:  st_nxt.tb_sel  = REG_WDATA;
        default:     st_nxt.tx_ctrl = st_r.tx_ctrl;
      endcase
    end
    // Reads answer one cycle later, unmapped reads give zero
    if (REG_RD) begin
      case (REG_ADDR)
        OFS_CODE0:   st_nxt.rdata = st_r.code[0];
        OFS_CODE1:   st_nxt.rdata = st_r.code[1];
        OFS_CODE2:   st_nxt.rdata = st_r.code[2];
        OFS_CODE3:   st_nxt.rdata = st_r.code[3];
        OFS_TX_CTRL: st_nxt.rdata = st_r.tx_ctrl;
        OFS_TX_SVC:  st_nxt.rdata = st_r.tx_svc;
        OFS_TX_LENH: st_nxt.rdata = st_r.tx_lenh;
        OFS_TX_LENL: st_nxt.rdata = st_r.tx_lenl;
        OFS_RX_STAT: st_nxt.rdata = rx_status;
        OFS_RX_SVC:  st_nxt.rdata = st_r.rx_svc;
        OFS_RX_LENH: st_nxt.rdata = st_r.rx_len[15:8];
        OFS_RX_LENL: st_nxt.rdata = st_r.rx_len[7:0];
        OFS_TB_SEL:  st_nxt.rdata = st_r.tb_sel;
        OFS_TB_MON:  st_nxt.rdata = st_r.test;
        default:     st_nxt.rdata = 8'h00;
      endcase
    end
    // Transmit code follows the rate bits, registered for timing
    st_nxt.tx_code = sel_code;
    // Receive status tracks decoder while the path is enabled
    if (!rx_en_s) begin
      st_nxt.rx_rate = RATE_DBPSK;
      st_nxt.rx_acq  = 1'b0;
      st_nxt.rx_sfd  = 1'b0;
      st_nxt.rx_sig  = 1'b0;
      st_nxt.rx_crc  = 1'b0;
    end else begin
      st_nxt.rx_acq = RX_ACQUIRED;
      st_nxt.rx_sfd = RX_SFD_FOUND;
      if (RX_SIG_STB) begin
        st_nxt.rx_sig  = code_hit(st_r.code, RX_SIG_FIELD);
        st_nxt.rx_rate = code_rate(st_r.code, RX_SIG_FIELD);
      end
      if (RX_CRC_STB) begin
        st_nxt.rx_crc = RX_CRC_OK;
      end
    end
    // Antenna survives a disabled path, only a good CRC moves it
    if (RX_CRC_STB && RX_CRC_OK) begin
      st_nxt.rx_ant = RX_ANT_A;
    end
    // Decoded header bytes
    if (RX_HDR_STB) begin
      st_nxt.rx_svc = RX_SERVICE;
      st_nxt.rx_len = RX_LENGTH;
    end
    // Test bus; monitor group levels move only on chip ticks, quiet groups clear at once, strobes every cycle
    case (st_r.tb_sel)
      TB_QUIET: begin
        st_nxt.test     = 8'h00;
        st_nxt.test_stb = 1'b0;
      end
      TB_RX_ACQ: begin
        if (CHIP_TICK) begin
          st_nxt.test = {ADC_FULL_SCALE, CARRIER_SENSE_FLAG,
                         ENERGY_DETECT_FLAG, RX_TRACK, RX_SFD_FOUND,
                         sig_rdy, len_rdy,
                         crc_due && st_r.rx_crc};
        end
        st_nxt.test_stb = RX_INIT_DETECT;
      end
      TB_TX_FIELD: begin
        if (CHIP_TICK) begin
          st_nxt.test = {ADC_FULL_SCALE, TX_PE_DELAYED,
                         TX_FIELD_FLAGS};
        end
        st_nxt.test_stb = SYMBOL_BOUNDARY_MARKER;
      end
      default: begin
        // Groups beyond 02h are not built here and stay quiet
        st_nxt.test     = 8'h00;
        st_nxt.test_stb = 1'b0;
      end
    endcase
  end

  // Register the whole state; constants only at reset
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st_r         <= '0;
      st_r.code[0] <= RST_CODE0;
      st_r.code[1] <= RST_CODE1;
      st_r.code[2] <= RST_CODE2;
      st_r.code[3] <= RST_CODE3;
      st_r.tx_code <= RST_CODE0;
      st_r.tx_svc  <= RST_BYTE;
      st_r.tb_sel  <= TB_QUIET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign REG_RDATA   = st_r.rdata;
  assign TX_RATE     = st_r.tx_ctrl[1:0];
  assign TX_SIG_CODE = st_r.tx_code;
  assign TX_SERVICE  = st_r.tx_svc;
  assign TX_LENGTH   = {st_r.tx_lenh, st_r.tx_lenl};
  assign TEST_OUT    = st_r.test;
  assign TEST_STB    = st_r.test_stb;

  // Checks on the registered behaviour
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  tx_code_sel_a: assert property (
    ##1 st_r.tx_code == $past(sel_code))
    else $error("transmit code does not follow rate");

  rate_off_a: assert property (
    !rx_en_s |=> st_r.rx_rate == RATE_DBPSK && !st_r.rx_acq)
    else $error("rate or acquire not cleared when disabled");

  sfd_follow_a: assert property (
    rx_en_s && RX_SFD_FOUND |=> st_r.rx_sfd)
    else $error("delimiter status missed");

  sig_nomatch_a: assert property (
    rx_en_s && RX_SIG_STB && !code_hit(st_r.code, RX_SIG_FIELD)
    |=> !st_r.rx_sig)
    else $error("signal valid on unknown code");

  crc_capture_a: assert property (
    rx_en_s && RX_CRC_STB |=> st_r.rx_crc == $past(RX_CRC_OK))
    else $error("CRC status not captured");

  ant_hold_a: assert property (
    !(RX_CRC_STB && RX_CRC_OK) |=> $stable(st_r.rx_ant))
    else $error("antenna changed without good CRC");

  stat_bit0_a: assert property (
    REG_RD && REG_ADDR == OFS_RX_STAT |=> REG_RDATA[0] == 1'b0)
    else $error("status bit 0 not zero");

  ro_write_a: assert property (
    REG_WR && REG_ADDR == OFS_RX_SVC && !RX_HDR_STB
    |=> $stable(st_r.rx_svc))
    else $error("write changed receive service");

  tb_quiet_a: assert property (
    (st_r.tb_sel == TB_QUIET) [*2] |-> TEST_OUT == 8'h00 && !TEST_STB)
    else $error("test bus not quiet");

  tb_chip_a: assert property (
    !CHIP_TICK && st_r.tb_sel == TB_RX_ACQ |=> $stable(TEST_OUT))
    else $error("monitor moved off a chip boundary");

  acq_follow_a: assert property (
    rx_en_s |=> st_r.rx_acq == $past(RX_ACQUIRED))
    else $error("acquire status not following decoder");

  hdr_capture_a: assert property (
    RX_HDR_STB |=> st_r.rx_svc == $past(RX_SERVICE)
    && st_r.rx_len == $past(RX_LENGTH))
    else $error("decoded header bytes not captured");

  ro_len_a: assert property (
    REG_WR && REG_ADDR == OFS_RX_LENH && !RX_HDR_STB
    |=> $stable(st_r.rx_len))
    else $error("write changed receive length");

  acq_stb_a: assert property (
    st_r.tb_sel == TB_RX_ACQ |=> TEST_STB == $past(RX_INIT_DETECT))
    else $error("acquisition strobe wrong");

  mark_stb_a: assert property (
    st_r.tb_sel == TB_TX_FIELD
    |=> TEST_STB == $past(SYMBOL_BOUNDARY_MARKER))
    else $error("transmit strobe not symbol marker");

  crc_ok_cv: cover property (RX_CRC_STB && RX_CRC_OK && rx_en_s);
  rx_mon_cv: cover property (st_r.tb_sel == TB_RX_ACQ && TEST_STB);
  top_rate_cv: cover property (TX_RATE == RATE_QWALSH
    ##1 TX_SIG_CODE == RST_CODE3);
endmodule // dhf_regs
`default_nettype wire

// >>> verif/dhf_mac_model.sv
// Controller model that drives the register port with reads and writes
`timescale 1ns/1ps
`default_nettype none
module dhf_mac_model (
  // Clock
  input  wire logic       clk,
  // Register port towards the bank
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  // Bus idle from time zero
  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // One-cycle write; the rate is set long before any frame needs it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d; // Released data must not keep its last value
  endtask

  // One-cycle read; data taken only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule // dhf_mac_model
`default_nettype wire

// >>> verif/dsss_header_field_and_test_monitor_regs_tb.sv
// Self-checking bench for the header field and test monitor registers
`timescale 1ns/1ps
`default_nettype none
module dsss_header_field_and_test_monitor_regs_tb;
  import dhf_pkg::*;
  logic        clk, nrst, wr, rd, en, acq, sfd, sig_stb, hdr_stb;
  logic        crc_stb, crc_ok, ant_a, tick, fs, csense, edet, trk, init_det;
  logic        txdly, mark, tstb;
  logic [7:0]  addr, wdata, rdata, sig_fld, svc, tx_code, tx_svc, tout;
  logic [5:0]  txflags;
  logic [1:0]  tx_rate;
  logic [15:0] len, tx_len;
  int          n_mismatch, n_tests;
  // Nominal code values, lowest rate first
  localparam logic [7:0] CODES [4] = '{8'h0a, 8'h14, 8'h37, 8'h6e};

  // Short header timer so the run stays brief
  dhf_regs #(.SIG_CYC(4), .LEN_CYC(8), .CRC_CYC(12)) dut (
    .SYS_CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .RECEIVE_PATH_ENABLE_PIN(en), .RX_ACQUIRED(acq), .RX_SFD_FOUND(sfd),
    .RX_SIG_STB(sig_stb), .RX_SIG_FIELD(sig_fld), .RX_HDR_STB(hdr_stb),
    .RX_SERVICE(svc), .RX_LENGTH(len), .RX_CRC_STB(crc_stb),
    .RX_CRC_OK(crc_ok), .RX_ANT_A(ant_a), .CHIP_TICK(tick),
    .ADC_FULL_SCALE(fs), .CARRIER_SENSE_FLAG(csense),
    .ENERGY_DETECT_FLAG(edet), .RX_TRACK(trk), .RX_INIT_DETECT(init_det),
    .TX_FIELD_FLAGS(txflags), .TX_PE_DELAYED(txdly),
    .SYMBOL_BOUNDARY_MARKER(mark), .TX_RATE(tx_rate),
    .TX_SIG_CODE(tx_code), .TX_SERVICE(tx_svc), .TX_LENGTH(tx_len),
    .TEST_OUT(tout), .TEST_STB(tstb)
  );

  // Controller on the far side of the register port
  dhf_mac_model mac (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
  );

  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  // Compare and count
  task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Read a register, then check that read data drops back to zero
  task automatic rchk(string n, logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    mac.rd_reg(a, d);
    chk(n, 16'(d), 16'(e));
    @(posedge clk);
    #1;
    chk("rdata_idle", 16'(rdata), 16'h0000);
  endtask

  // Let some cycles pass and sample settled outputs
  task automatic waitc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Signal field, header and CRC results delivered in one cycle
  task automatic hdr(logic [7:0] f, logic ok, logic a);
    @(posedge clk);
    sig_stb <= 1'b1;
    hdr_stb <= 1'b1;
    crc_stb <= 1'b1;
    sig_fld <= f;
    crc_ok  <= ok;
    ant_a   <= a;
    @(posedge clk);
    sig_stb <= 1'b0;
    hdr_stb <= 1'b0;
    crc_stb <= 1'b0;
    waitc(2);
  endtask

  // Single end of run
  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, far beyond the roughly 150 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {clk, nrst, sig_stb, hdr_stb, crc_stb, crc_ok, ant_a, sfd, edet} = '0;
    {en, acq, tick, fs, csense, trk, init_det, txdly, mark} = '1;
    sig_fld = 8'h00;
    svc = 8'h5a;
    len = 16'hbeef;
    txflags = 6'h2a;
    n_mismatch = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    // Reset values
    for (int i = 0; i < 4; i++) begin
      rchk("code", 8'(8'h40 + 4 * i), CODES[i]);
    end
    rchk("tb_sel", OFS_TB_SEL, 8'h00);
    // Every rate picks its code
    for (int r = 3; r >= 0; r--) begin
      mac.wr_reg(OFS_TX_CTRL, 8'(r));
      waitc(2);
      chk("tx_rate", 16'(tx_rate), 16'(r));
      chk("tx_code", 16'(tx_code), 16'(CODES[r]));
    end
    mac.wr_reg(OFS_TX_SVC, 8'h00);
    mac.wr_reg(OFS_TX_LENH, 8'h12);
    mac.wr_reg(OFS_TX_LENL, 8'h34);
    waitc(2);
    chk("tx_svc", 16'(tx_svc), 16'h0000);
    chk("tx_len", tx_len, 16'h1234);
    // Quiet bus despite busy sources
    chk("quiet_out", 16'(tout), 16'h0000);
    chk("quiet_stb", 16'(tstb), 16'h0000);
    // Receive status sequence
    @(posedge clk);
    sfd <= 1'b1;
    hdr(8'h37, 1'b1, 1'b1);
    rchk("stat_a", OFS_RX_STAT, 8'hbe);
    hdr(8'h99, 1'b0, 1'b0);
    rchk("stat_b", OFS_RX_STAT, 8'h32);
    hdr(8'h6e, 1'b1, 1'b0);
    rchk("stat_c", OFS_RX_STAT, 8'hfc);
    // Carrier lost: acquire bit drops back to searching
    @(posedge clk);
    acq <= 1'b0;
    hdr(8'h14, 1'b1, 1'b1);
    mac.wr_reg(OFS_RX_STAT, 8'hff);
    mac.wr_reg(OFS_RX_SVC, 8'h00);
    mac.wr_reg(OFS_RX_LENH, 8'h00);
    rchk("stat_d", OFS_RX_STAT, 8'h5e);
    rchk("rx_svc", OFS_RX_SVC, 8'h5a);
    rchk("rx_lenh", OFS_RX_LENH, 8'hbe);
    rchk("rx_lenl", OFS_RX_LENL, 8'hef);
    // Receive acquisition group
    mac.wr_reg(OFS_TB_SEL, TB_RX_ACQ);
    waitc(3);
    chk("acq_out", 16'(tout), 16'h00df);
    chk("acq_stb", 16'(tstb), 16'h0001);
    rchk("mon_rd", OFS_TB_MON, 8'hdf);
    // Levels move only on chip ticks
    @(posedge clk);
    tick <= 1'b0;
    trk  <= 1'b0;
    init_det <= 1'b0;
    waitc(3);
    chk("hold_out", 16'(tout), 16'h00df);
    chk("init_off", 16'(tstb), 16'h0000);
    @(posedge clk);
    tick <= 1'b1;
    waitc(2);
    chk("tick_out", 16'(tout), 16'h00cf);
    // End of message clears, then header flags follow delimiter
    @(posedge clk);
    sfd <= 1'b0;
    waitc(3);
    chk("clr_out", 16'(tout), 16'h00c0);
    @(posedge clk);
    sfd <= 1'b1;
    waitc(2);
    chk("hdr_none", 16'(tout[2:0]), 16'h0000);
    waitc(6);
    chk("hdr_sig", 16'(tout[2:0]), 16'h0004);
    waitc(8);
    chk("hdr_all", 16'(tout[2:0]), 16'h0007);
    // Transmit field group
    mac.wr_reg(OFS_TB_SEL, TB_TX_FIELD);
    waitc(3);
    chk("tx_out", 16'(tout), 16'h00ea);
    chk("tx_stb", 16'(tstb), 16'h0001);
    rchk("tx_mon", OFS_TB_MON, 8'hea);
    @(posedge clk);
    mark <= 1'b0;
    waitc(2);
    chk("mark_off", 16'(tstb), 16'h0000);
    mac.wr_reg(OFS_TB_SEL, 8'h03);
    waitc(3);
    chk("other_out", 16'(tout), 16'h0000);
    rchk("unmapped", 8'h10, 8'h00);
    // Disabled path clears status but keeps antenna
    @(posedge clk);
    en <= 1'b0;
    waitc(4);
    rchk("off", OFS_RX_STAT, 8'h02);
    tally_and_finish();
  end
endmodule // dsss_header_field_and_test_monitor_regs_tb
`default_nettype wire
